// ===== cgps_sequencer.sv
// Power-up / power-down sequencer of a single-PLL clock generator.
// Assumes APB master on clk; all pin inputs are asynchronous.
//
// Function
// - Hold in reset until core and output supply monitors both report good.
// - With crystal selected, wait for amplitude detector before calibration.
// - Calibration wait counts 10 MHz ticks, length chosen by wait bits 3:2.
// - VCO wait follows, counting 10 MHz ticks, length from wait bits 1:0.
// - Clock outputs turn on right after the VCO wait, not waiting for lock.
// - Routed lock-lost indicator drops at the first phase-detector rising edge after lock.
// - Enable pin low powers everything down and reports device disabled.
// - Enable rising starts power-on sequence, registers loaded from strap pins.
// - Register writes ignored, reads answered with zero data and no error while enable pin is low.
// - After power-on release, start sequencing counters, then calibrate.
// - Soft-reset bit write reruns the full power-on sequence.
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module cgps_sequencer #(
  parameter int unsigned CAL_TICKS0 = cgps_pkg::CAL_US0 * cgps_pkg::OSC_TICKS_PER_US,
  parameter int unsigned CAL_TICKS1 = cgps_pkg::CAL_US1 * cgps_pkg::OSC_TICKS_PER_US,
  parameter int unsigned CAL_TICKS2 = cgps_pkg::CAL_US2 * cgps_pkg::OSC_TICKS_PER_US,
  parameter int unsigned CAL_TICKS3 = cgps_pkg::CAL_US3 * cgps_pkg::OSC_TICKS_PER_US,
  parameter int unsigned VCO_TICKS0 = cgps_pkg::VCO_US0 * cgps_pkg::OSC_TICKS_PER_US,
  parameter int unsigned VCO_TICKS1 = cgps_pkg::VCO_US1 * cgps_pkg::OSC_TICKS_PER_US,
  parameter int unsigned VCO_TICKS2 = cgps_pkg::VCO_US2 * cgps_pkg::OSC_TICKS_PER_US,
  parameter int unsigned VCO_TICKS3 = cgps_pkg::VCO_US3 * cgps_pkg::OSC_TICKS_PER_US
) (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic                          ce,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [cgps_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [cgps_pkg::DATA_W-1:0]   pwdata,
  output logic      [cgps_pkg::DATA_W-1:0]   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          chipDisableN,
  input  wire logic                          coreSupplyOk,
  input  wire logic                          outSupplyOk,
  input  wire logic                          xtalAmpOk,
  input  wire logic                          pllLocked,
  input  wire logic                          pfdClk,
  input  wire logic [cgps_pkg::STRAP_W-1:0]  cfgStrap,
  output logic                               clkOutEnable,
  output logic                               indicatorPinA,
  output logic                               indicatorPinB,
  output logic                               deviceDisabled
);

  if (CAL_TICKS0 < 1 || CAL_TICKS1 < 1 || CAL_TICKS2 < 1 || CAL_TICKS3 < 1 ||
      VCO_TICKS0 < 1 || VCO_TICKS1 < 1 || VCO_TICKS2 < 1 || VCO_TICKS3 < 1) begin : g_chk
    $error("cgps_sequencer: every wait needs at least one tick");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic regHit(input logic [cgps_pkg::ADDR_W-1:0] addr,
                                  input logic [cgps_pkg::ADDR_W-1:0] idx);
    regHit = (addr == {idx[cgps_pkg::ADDR_W-3:0], 2'h0});
  endfunction : regHit

  function automatic logic [cgps_pkg::CNT_W-1:0] pickTicks(
      input logic [cgps_pkg::SEL_W-1:0] sel,
      input int unsigned t0, input int unsigned t1,
      input int unsigned t2, input int unsigned t3);
    case (sel)
      2'h0:    pickTicks = cgps_pkg::CNT_W'(t0);
      2'h1:    pickTicks = cgps_pkg::CNT_W'(t1);
      2'h2:    pickTicks = cgps_pkg::CNT_W'(t2);
      default: pickTicks = cgps_pkg::CNT_W'(t3);
    endcase
  endfunction : pickTicks

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int EN_B   = 0;
  localparam int CORE_B = 1;
  localparam int OUT_B  = 2;
  localparam int XTAL_B = 3;
  localparam int LOCK_B = 4;

  logic [cgps_pkg::SYNC_W-1:0]  pinSync1_r, pinSync1_nxt;
  logic [cgps_pkg::SYNC_W-1:0]  pinSync2_r, pinSync2_nxt;
  logic [cgps_pkg::STRAP_W-1:0] strapSync1_r, strapSync1_nxt;
  logic [cgps_pkg::STRAP_W-1:0] strapSync2_r, strapSync2_nxt;
  logic                         pfdSync1_r, pfdSync1_nxt;
  logic                         pfdSync2_r, pfdSync2_nxt;
  logic                         pfdSync3_r, pfdSync3_nxt;

  cgps_pkg::cgps_state_t        state_r, state_nxt;
  logic [cgps_pkg::WAIT_W-1:0]  waitCfg_r, waitCfg_nxt;
  logic [cgps_pkg::SEQ_W-1:0]   seqCfg_r, seqCfg_nxt;
  logic                         lockLostFlag_r, lockLostFlag_nxt;
  logic                         clkOutEnable_r, clkOutEnable_nxt;
  logic                         indicatorPinA_r, indicatorPinA_nxt;
  logic                         indicatorPinB_r, indicatorPinB_nxt;
  logic                         deviceDisabled_r, deviceDisabled_nxt;
  logic [cgps_pkg::DATA_W-1:0]  prdata_r, prdata_nxt;
  logic                         pready_r, pready_nxt;
  logic                         pslverr_r, pslverr_nxt;

  logic                         enabled;
  logic                         powerOk;
  logic                         pfdEdge;
  logic                         apbSetup;
  logic                         apbWrite;
  logic                         mapped;
  logic                         softRst;
  logic [cgps_pkg::DATA_W-1:0]  readData;

  cgps_timer_if tif ();

  cgps_wait_timer #(
    .ACC_W (16)
  ) u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .tif     (tif.tmr)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    pinSync1_nxt   = {pllLocked, xtalAmpOk, outSupplyOk, coreSupplyOk, chipDisableN};
    pinSync2_nxt   = pinSync1_r;
    strapSync1_nxt = cfgStrap;
    strapSync2_nxt = strapSync1_r;
    pfdSync1_nxt   = pfdClk;
    pfdSync2_nxt   = pfdSync1_r;
    pfdSync3_nxt   = pfdSync2_r;

    enabled  = pinSync2_r[EN_B];
    powerOk  = enabled && pinSync2_r[CORE_B] && pinSync2_r[OUT_B];
    pfdEdge  = pfdSync2_r && !pfdSync3_r;

    apbSetup = psel && !penable;
    apbWrite = psel && penable && pready_r && pwrite && enabled;
    mapped   = regHit(paddr, cgps_pkg::IDX_CTRL) || regHit(paddr, cgps_pkg::IDX_WAIT) ||
               regHit(paddr, cgps_pkg::IDX_SEQCFG) || regHit(paddr, cgps_pkg::IDX_STATUS);
    softRst  = apbWrite && regHit(paddr, cgps_pkg::IDX_CTRL) &&
               pwdata[cgps_pkg::CTRL_SOFTRST_BIT];

    readData = '0;
    if (regHit(paddr, cgps_pkg::IDX_WAIT)) begin
      readData[cgps_pkg::WAIT_W-1:0] = waitCfg_r;
    end else if (regHit(paddr, cgps_pkg::IDX_SEQCFG)) begin
      readData[cgps_pkg::SEQ_W-1:0] = seqCfg_r;
    end else if (regHit(paddr, cgps_pkg::IDX_STATUS)) begin
      readData[cgps_pkg::STATE_W-1:0]     = state_r;
      readData[cgps_pkg::STAT_OE_BIT]  = clkOutEnable_r;
      readData[cgps_pkg::STAT_LOL_BIT] = lockLostFlag_r;
      readData[cgps_pkg::STAT_DIS_BIT] = deviceDisabled_r;
    end

    // Register writes
    waitCfg_nxt = waitCfg_r;
    seqCfg_nxt  = seqCfg_r;
    if (apbWrite && regHit(paddr, cgps_pkg::IDX_WAIT)) begin
      waitCfg_nxt = pwdata[cgps_pkg::WAIT_W-1:0];
    end
    if (apbWrite && regHit(paddr, cgps_pkg::IDX_SEQCFG)) begin
      seqCfg_nxt = pwdata[cgps_pkg::SEQ_W-1:0];
    end

    // Sequencer
    state_nxt = state_r;
    tif.start = 1'b0;
    tif.ticks = pickTicks(waitCfg_r[cgps_pkg::WAIT_CAL_LSB +: cgps_pkg::SEL_W],
                          CAL_TICKS0, CAL_TICKS1, CAL_TICKS2, CAL_TICKS3);
    if (!powerOk) begin
      state_nxt = cgps_pkg::ST_OFF;
    end else if (softRst) begin
      state_nxt = cgps_pkg::ST_POR;
    end else begin
      case (state_r)
        cgps_pkg::ST_OFF: begin
          state_nxt = cgps_pkg::ST_POR;
        end
        cgps_pkg::ST_POR: begin
          waitCfg_nxt = strapSync2_r[cgps_pkg::STRAP_WAIT_LSB +: cgps_pkg::WAIT_W];
          seqCfg_nxt  = strapSync2_r[cgps_pkg::STRAP_SEQ_LSB +: cgps_pkg::SEQ_W];
          state_nxt   = cgps_pkg::ST_XO;
        end
        cgps_pkg::ST_XO: begin
          if (!seqCfg_r[cgps_pkg::SEQ_XTAL_BIT] || pinSync2_r[XTAL_B]) begin
            tif.start = 1'b1;
            state_nxt = cgps_pkg::ST_CAL;
          end
        end
        cgps_pkg::ST_CAL: begin
          if (tif.done) begin
            tif.start = 1'b1;
            tif.ticks = pickTicks(waitCfg_r[cgps_pkg::WAIT_VCO_LSB +: cgps_pkg::SEL_W],
                                  VCO_TICKS0, VCO_TICKS1, VCO_TICKS2, VCO_TICKS3);
            state_nxt = cgps_pkg::ST_VCO;
          end
        end
        cgps_pkg::ST_VCO: begin
          if (tif.done) begin
            state_nxt = cgps_pkg::ST_RUN;
          end
        end
        cgps_pkg::ST_RUN: begin
          state_nxt = cgps_pkg::ST_RUN;
        end
        default: begin
          state_nxt = cgps_pkg::ST_OFF;
        end
      endcase
    end

    clkOutEnable_nxt   = (state_nxt == cgps_pkg::ST_RUN);
    deviceDisabled_nxt = !enabled;

    lockLostFlag_nxt = lockLostFlag_r;
    if (state_nxt != cgps_pkg::ST_RUN || !pinSync2_r[LOCK_B]) begin
      lockLostFlag_nxt = 1'b1;
    end else if (pfdEdge) begin
      lockLostFlag_nxt = 1'b0;
    end
    indicatorPinA_nxt = seqCfg_nxt[cgps_pkg::SEQ_PINA_BIT] && lockLostFlag_nxt;
    indicatorPinB_nxt = seqCfg_nxt[cgps_pkg::SEQ_PINB_BIT] && lockLostFlag_nxt;

    // APB answer, one access cycle
    pready_nxt  = apbSetup;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    if (apbSetup) begin
      prdata_nxt  = enabled ? readData : '0;
      pslverr_nxt = enabled && !mapped;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinSync1_r       <= '0;
      pinSync2_r       <= '0;
      strapSync1_r     <= '0;
      strapSync2_r     <= '0;
      pfdSync1_r       <= 1'b0;
      pfdSync2_r       <= 1'b0;
      pfdSync3_r       <= 1'b0;
      state_r          <= cgps_pkg::ST_OFF;
      waitCfg_r        <= cgps_pkg::WAIT_RST;
      seqCfg_r         <= cgps_pkg::SEQ_RST;
      lockLostFlag_r   <= 1'b1;
      clkOutEnable_r   <= 1'b0;
      indicatorPinA_r  <= 1'b0;
      indicatorPinB_r  <= 1'b0;
      deviceDisabled_r <= 1'b1;
      prdata_r         <= '0;
      pready_r         <= 1'b0;
      pslverr_r        <= 1'b0;
    end else if (ce) begin
      pinSync1_r       <= pinSync1_nxt;
      pinSync2_r       <= pinSync2_nxt;
      strapSync1_r     <= strapSync1_nxt;
      strapSync2_r     <= strapSync2_nxt;
      pfdSync1_r       <= pfdSync1_nxt;
      pfdSync2_r       <= pfdSync2_nxt;
      pfdSync3_r       <= pfdSync3_nxt;
      state_r          <= state_nxt;
      waitCfg_r        <= waitCfg_nxt;
      seqCfg_r         <= seqCfg_nxt;
      lockLostFlag_r   <= lockLostFlag_nxt;
      clkOutEnable_r   <= clkOutEnable_nxt;
      indicatorPinA_r  <= indicatorPinA_nxt;
      indicatorPinB_r  <= indicatorPinB_nxt;
      deviceDisabled_r <= deviceDisabled_nxt;
      prdata_r         <= prdata_nxt;
      pready_r         <= pready_nxt;
      pslverr_r        <= pslverr_nxt;
    end
  end

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign clkOutEnable   = clkOutEnable_r;
  assign indicatorPinA  = indicatorPinA_r;
  assign indicatorPinB  = indicatorPinB_r;
  assign deviceDisabled = deviceDisabled_r;

endmodule : cgps_sequencer

`default_nettype wire

// ===== cgps_pkg.sv
// Constants, register map and types of the power-up sequencer.
// Assumes a 25 MHz system clock and a 10 MHz internal timing oscillator.
`default_nettype none

package cgps_pkg;

  // ----------------------------------------------------------------
  // Clock rates
  // ----------------------------------------------------------------
  localparam int unsigned SYS_KHZ = 25000;
  localparam int unsigned OSC_KHZ = 10000;
  localparam int unsigned OSC_TICKS_PER_US = OSC_KHZ / 1000;

  // ----------------------------------------------------------------
  // Bus and register indices
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 32;
  localparam logic [ADDR_W-1:0] IDX_CTRL   = 12'h00C;
  localparam logic [ADDR_W-1:0] IDX_WAIT   = 12'h077;
  localparam logic [ADDR_W-1:0] IDX_SEQCFG = 12'h078;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 12'h079;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  localparam int CTRL_SOFTRST_BIT = 7;
  localparam int SEL_W            = 2;
  localparam int WAIT_W           = 4;
  localparam int WAIT_CAL_LSB     = 2;
  localparam int WAIT_VCO_LSB     = 0;
  localparam int SEQ_W            = 3;
  localparam int SEQ_XTAL_BIT     = 0;
  localparam int SEQ_PINA_BIT     = 1;
  localparam int SEQ_PINB_BIT     = 2;
  localparam int STATE_W          = 3;
  localparam int STAT_OE_BIT      = 3;
  localparam int STAT_LOL_BIT     = 4;
  localparam int STAT_DIS_BIT     = 5;
  localparam int STRAP_W          = 7;
  localparam int STRAP_WAIT_LSB   = 0;
  localparam int STRAP_SEQ_LSB    = 4;
  localparam int SYNC_W           = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [WAIT_W-1:0] WAIT_RST = 4'h5;
  localparam logic [SEQ_W-1:0]  SEQ_RST  = 3'h2;

  // ----------------------------------------------------------------
  // Wait durations per select code, microseconds
  // ----------------------------------------------------------------
  localparam int unsigned CAL_US0 = 30;
  localparam int unsigned CAL_US1 = 300;
  localparam int unsigned CAL_US2 = 30000;
  localparam int unsigned CAL_US3 = 300000;
  localparam int unsigned VCO_US0 = 20;
  localparam int unsigned VCO_US1 = 200;
  localparam int unsigned VCO_US2 = 20000;
  localparam int unsigned VCO_US3 = 200000;

  typedef enum logic [STATE_W-1:0] {
    ST_OFF, ST_POR, ST_XO, ST_CAL, ST_VCO, ST_RUN
  } cgps_state_t;

endpackage : cgps_pkg

`default_nettype wire

// ===== cgps_timer_if.sv
// Start/done handshake between sequencer and wait timer.
// Assumes both ends on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface cgps_timer_if;
  logic                     start;
  logic [cgps_pkg::CNT_W-1:0] ticks;
  logic                     done;
  modport seq (output start, output ticks, input done);
  modport tmr (input start, input ticks, output done);
endinterface : cgps_timer_if

`default_nettype wire

// ===== cgps_wait_timer.sv
// Wait timer counting ticks of the internal 10 MHz oscillator.
// Assumes a synchronous high reset and a clock enable from the top.
`timescale 1ns/1ps
`default_nettype none

module cgps_wait_timer #(
  parameter int ACC_W = 16
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  cgps_timer_if.tmr tif
);

  if (ACC_W < 16) begin : g_chk
    $error("cgps_wait_timer: ACC_W too small for oscillator ratio");
  end

  localparam logic [ACC_W-1:0] OSC_STEP = ACC_W'(cgps_pkg::OSC_KHZ);
  localparam logic [ACC_W-1:0] SYS_MOD  = ACC_W'(cgps_pkg::SYS_KHZ);

  logic [ACC_W-1:0]           acc_r, acc_nxt;
  logic [cgps_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic                       busy_r, busy_nxt;
  logic                       done_r, done_nxt;
  logic                       oscTick;

  // ----------------------------------------------------------------
  // Oscillator tick and countdown
  // ----------------------------------------------------------------
  always_comb begin
    acc_nxt  = acc_r + OSC_STEP;
    oscTick  = 1'b0;
    if (acc_nxt >= SYS_MOD) begin
      acc_nxt = acc_nxt - SYS_MOD;
      oscTick = 1'b1;
    end
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    done_nxt = done_r;
    if (tif.start) begin
      cnt_nxt  = tif.ticks;
      busy_nxt = 1'b1;
      done_nxt = 1'b0;
    end else if (busy_r && oscTick) begin
      if (cnt_r <= 32'h0000_0001) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_r  <= '0;
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (ce) begin
      acc_r  <= acc_nxt;
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign tif.done = done_r;

endmodule : cgps_wait_timer

`default_nettype wire

// ===== cgps_seq_checker.sv
// Concurrent checks on the sequencer's top-level ports.
// Assumes one clock domain, synchronous high reset, ce held high.
`timescale 1ns/1ps
`default_nettype none

module cgps_seq_checker (
  input wire logic                        clk,
  input wire logic                        sys_rst,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic [cgps_pkg::DATA_W-1:0] prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        chipDisableN,
  input wire logic                        coreSupplyOk,
  input wire logic                        outSupplyOk,
  input wire logic                        pllLocked,
  input wire logic                        pfdClk,
  input wire logic                        clkOutEnable,
  input wire logic                        indicatorPinA,
  input wire logic                        deviceDisabled
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ------------------------------------------------------------
  // Sequences
  // ------------------------------------------------------------
  sequence pinLow;
    !chipDisableN [*5];
  endsequence
  sequence pfdQuiet;
    !pfdClk [*6];
  endsequence
  sequence busShut;
    deviceDisabled ##1 (pready && deviceDisabled) ##1 deviceDisabled;
  endsequence

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  pin_low_off_a: assert property (pinLow |-> deviceDisabled && !clkOutEnable)
    else $error("outputs on while enable pin low");
  core_loss_off_a: assert property (!coreSupplyOk [*5] |-> !clkOutEnable)
    else $error("outputs on without core supply");
  out_loss_off_a: assert property (!outSupplyOk [*5] |-> !clkOutEnable)
    else $error("outputs on without output supply");
  wait_first_a: assert property ($rose(clkOutEnable) |-> $past(deviceDisabled, 8) == 1'b0)
    else $error("outputs on too soon after enable");
  lock_clear_a: assert property ($fell(indicatorPinA) |-> clkOutEnable && pllLocked)
    else $error("lock flag dropped without lock");
  lock_hold_a: assert property (pfdQuiet ##0 indicatorPinA |=> indicatorPinA)
    else $error("lock flag dropped without phase clock");
  bus_answer_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  bus_single_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  bus_refused_a: assert property (busShut |-> $past(prdata) == 32'h0 && !$past(pslverr))
    else $error("bus answered while disabled");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule : cgps_seq_checker

bind cgps_sequencer cgps_seq_checker u_cgps_seq_checker (
  .clk, .sys_rst, .psel, .penable, .prdata, .pready, .pslverr, .chipDisableN,
  .coreSupplyOk, .outSupplyOk, .pllLocked, .pfdClk, .clkOutEnable, .indicatorPinA,
  .deviceDisabled
);

`default_nettype wire

// ===== cgps_board_model.sv
// Board and PLL model: pins, supplies, crystal, lock, phase clock.
// Assumes commands from the bench, changed on the rising edge.
`timescale 1ns/1ps
`default_nettype none

module cgps_board_model (
  input  wire logic clk,
  input  wire logic enCmd,
  input  wire logic coreCmd,
  input  wire logic outCmd,
  input  wire logic xtalCmd,
  input  wire logic clkOutEnable,
  output var logic  chipDisableN,
  output var logic  coreSupplyOk,
  output var logic  outSupplyOk,
  output var logic  xtalAmpOk,
  output var logic  pllLocked,
  output var logic  pfdClk
);
  logic [3:0] lockCnt;
  logic [1:0] pfdCnt;

  initial begin
    {chipDisableN, coreSupplyOk, outSupplyOk, xtalAmpOk} = 4'h0;
    {pllLocked, pfdClk} = 2'h0;
    lockCnt = 4'h0;
    pfdCnt = 2'h0;
  end

  // Pin levels follow commands one edge later
  always @(posedge clk) begin
    chipDisableN <= enCmd;
    coreSupplyOk <= coreCmd;
    outSupplyOk <= outCmd;
    xtalAmpOk <= xtalCmd;
    lockCnt <= !clkOutEnable ? 4'h0 : (lockCnt == 4'hF ? lockCnt : lockCnt + 4'h1);
    pllLocked <= lockCnt >= 4'h6;
    pfdCnt <= pfdCnt == 2'h2 ? 2'h0 : pfdCnt + 2'h1;
    if (pfdCnt == 2'h2) begin
      pfdClk <= clkOutEnable ? ~pfdClk : 1'b0;
    end
  end
endmodule : cgps_board_model

`default_nettype wire

// ===== tb_top.sv
// Testbench: APB tasks plus board model around the sequencer.
// Assumes short tick parameters set here; ce dropped once to check the freeze.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %0t: got %0h expected %0h", $time, g, e); end end

module tb_top;
  logic                        clk, sys_rst, ce, psel, penable, pwrite;
  logic                        pready, pslverr, err;
  logic [cgps_pkg::ADDR_W-1:0] paddr;
  logic [cgps_pkg::DATA_W-1:0] pwdata, prdata, rd;
  logic [cgps_pkg::STRAP_W-1:0] cfgStrap;
  logic                        enCmd, coreCmd, outCmd, xtalCmd;
  logic                        chipDisableN, coreSupplyOk, outSupplyOk, xtalAmpOk;
  logic                        pllLocked, pfdClk, clkOutEnable;
  logic                        indicatorPinA, indicatorPinB, deviceDisabled;
  int                          miscompares, testsRun, n, t;

  cgps_sequencer #(.CAL_TICKS0(8), .CAL_TICKS1(24), .CAL_TICKS2(40), .CAL_TICKS3(56),
    .VCO_TICKS0(2), .VCO_TICKS1(6), .VCO_TICKS2(10), .VCO_TICKS3(14)) u_cgps_sequencer (
    .clk, .sys_rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .chipDisableN, .coreSupplyOk, .outSupplyOk, .xtalAmpOk, .pllLocked,
    .pfdClk, .cfgStrap, .clkOutEnable, .indicatorPinA, .indicatorPinB, .deviceDisabled);

  cgps_board_model u_cgps_board_model (.clk, .enCmd, .coreCmd, .outCmd, .xtalCmd,
    .clkOutEnable, .chipDisableN, .coreSupplyOk, .outSupplyOk, .xtalAmpOk, .pllLocked,
    .pfdClk);

  always #20 clk = ~clk;

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task automatic timeout();
    miscompares++;
    $display("ERROR %0t: wait ran out", $time);
    summarize();
  endtask : timeout

  task automatic apb(input logic wr, input logic [cgps_pkg::ADDR_W-1:0] idx,
                     input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= idx << 2;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) timeout();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic waitOut(input logic want, input int lim);
    n = 0;
    while (clkOutEnable !== want) begin
      @(posedge clk);
      n++;
      if (n > lim) timeout();
    end
  endtask : waitOut

  task automatic drivePins(input logic en, input logic core, input logic out,
                           input logic xtal);
    {enCmd, coreCmd, outCmd, xtalCmd} <= {en, core, out, xtal};
  endtask : drivePins

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    ce = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    cfgStrap = 7'h69;
    {enCmd, coreCmd, outCmd, xtalCmd} = 4'h4;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK({deviceDisabled, clkOutEnable}, 2'b10)
    apb(1'b0, cgps_pkg::IDX_STATUS, 32'h0);
    `CHK({err, rd}, 33'h0)
    drivePins(1'b1, 1'b1, 1'b0, 1'b0);
    repeat (60) @(posedge clk);
    `CHK({deviceDisabled, clkOutEnable}, 2'b00)
    drivePins(1'b1, 1'b1, 1'b1, 1'b0);
    waitOut(1'b1, 400);
    `CHK(n >= 112 && n <= 135, 1'b1)
    `CHK({indicatorPinA, indicatorPinB, pllLocked}, 3'b110)
    n = 0;
    while (indicatorPinA !== 1'b0) begin
      @(posedge clk);
      n++;
      if (n > 100) timeout();
    end
    `CHK({indicatorPinB, pllLocked}, 2'b01)
    apb(1'b0, cgps_pkg::IDX_STATUS, 32'h0);
    `CHK({err, rd[5:0]}, 7'h0D)
    apb(1'b0, cgps_pkg::IDX_WAIT, 32'h0);
    `CHK({err, rd}, 33'h9)
    apb(1'b0, cgps_pkg::IDX_SEQCFG, 32'h0);
    `CHK({err, rd}, 33'h6)
    apb(1'b1, cgps_pkg::IDX_WAIT, 32'h3);
    apb(1'b0, cgps_pkg::IDX_WAIT, 32'h0);
    `CHK({err, rd}, 33'h3)
    apb(1'b0, 12'h0FF, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    // Code c picks calibration wait c and VCO wait 3 - c
    for (int c = 0; c < 4; c++) begin
      cfgStrap <= {3'b110, 2'(c), 2'(3 - c)};
      if (c == 3) begin
        drivePins(1'b0, 1'b1, 1'b1, 1'b0);
        repeat (8) @(posedge clk);
        `CHK({deviceDisabled, clkOutEnable}, 2'b10)
        apb(1'b0, cgps_pkg::IDX_WAIT, 32'h0);
        `CHK({err, rd}, 33'h0)
        drivePins(1'b1, 1'b1, 1'b1, 1'b0);
        t = 0;
      end else begin
        apb(1'b1, cgps_pkg::IDX_CTRL, 32'h80);
        waitOut(1'b0, 20);
        t = n;
      end
      waitOut(1'b1, 400);
      `CHK(t + n >= 30 * c + 52 && t + n <= 30 * c + 75, 1'b1)
    end
    cfgStrap <= 7'h79;
    apb(1'b1, cgps_pkg::IDX_CTRL, 32'h80);
    repeat (200) @(posedge clk);
    apb(1'b0, cgps_pkg::IDX_STATUS, 32'h0);
    `CHK({clkOutEnable, rd[5:0]}, 7'h12)
    apb(1'b1, cgps_pkg::IDX_SEQCFG, 32'h3);
    @(posedge clk);
    `CHK({indicatorPinA, indicatorPinB}, 2'b10)
    apb(1'b0, cgps_pkg::IDX_SEQCFG, 32'h0);
    `CHK({err, rd}, 33'h3)
    drivePins(1'b1, 1'b1, 1'b1, 1'b1);
    waitOut(1'b1, 200);
    apb(1'b1, cgps_pkg::IDX_CTRL, 32'h80);
    repeat (30) @(posedge clk);
    drivePins(1'b1, 1'b0, 1'b1, 1'b1);
    repeat (8) @(posedge clk);
    apb(1'b0, cgps_pkg::IDX_STATUS, 32'h0);
    `CHK({clkOutEnable, rd[5:0]}, 7'h10)
    drivePins(1'b1, 1'b1, 1'b1, 1'b1);
    ce <= 1'b0;
    repeat (200) @(posedge clk);
    `CHK({deviceDisabled, clkOutEnable}, 2'b00)
    ce <= 1'b1;
    waitOut(1'b1, 300);
    summarize();
  end
endmodule : tb_top

`default_nettype wire
